// ===== irq_ctrl_pkg.sv
// constants, register map and types of the interrupt control unit
package irq_ctrl_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_INTERRUPT_CONTROL = 14'h000B;
  localparam logic [13:0] IDX_PERIPH_IRQ_ENABLE_0 = 14'h0096;
  localparam logic [13:0] IDX_PERIPH_IRQ_ENABLE_1 = 14'h0097;
  localparam logic [13:0] IDX_PIR0 = 14'h008C;
  localparam logic [13:0] IDX_PIR1 = 14'h008D;
  localparam logic [13:0] IDX_PINSEL = 14'h1E90;
  localparam logic [13:0] IDX_SHADOW0 = 14'h1FE8;
  localparam logic [15:0] ADDR_INTERRUPT_CONTROL = {IDX_INTERRUPT_CONTROL, 2'h0};
  localparam logic [15:0] ADDR_PERIPH_IRQ_ENABLE_0 = {IDX_PERIPH_IRQ_ENABLE_0, 2'h0};
  localparam logic [15:0] ADDR_PERIPH_IRQ_ENABLE_1 = {IDX_PERIPH_IRQ_ENABLE_1, 2'h0};
  localparam logic [15:0] ADDR_PIR0 = {IDX_PIR0, 2'h0};
  localparam logic [15:0] ADDR_PIR1 = {IDX_PIR1, 2'h0};
  localparam logic [15:0] ADDR_PINSEL = {IDX_PINSEL, 2'h0};
  localparam logic [15:0] ADDR_SHADOW0 = {IDX_SHADOW0, 2'h0};
  // control register fields
  localparam int GIE_BIT = 7;
  localparam int PERIPH_GROUP_ENABLE_BIT = 6;
  localparam int EDGE_BIT = 0;
  localparam logic [7:0] INTERRUPT_CONTROL_MASK = 8'hC1;
  localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h01;
  // first enable / request register fields
  localparam int TMR0_BIT = 5;
  localparam int IOC_BIT = 4;
  localparam int EXT_BIT = 0;
  localparam logic [7:0] PERIPH_IRQ_ENABLE_0_MASK = 8'h31;
  localparam logic [7:0] PERIPH_IRQ_ENABLE_1_MASK = 8'hFD;
  localparam logic [7:0] WAKE_MASK0 = 8'h11;
  // instruction cycle of four clock phases
  localparam logic [1:0] Q1_PHASE = 2'h0;
  localparam logic [1:0] PHASE_STEP = 2'h1;
  // context shadow slots
  localparam int SHADOW_N = 8;
  localparam logic [2:0] SH_WORKING_REGISTER = 3'h0;
  localparam logic [2:0] SH_STATUS = 3'h1;
  localparam logic [2:0] SH_BSR = 3'h2;
  localparam logic [2:0] SH_FSR0L = 3'h3;
  localparam logic [2:0] SH_FSR0H = 3'h4;
  localparam logic [2:0] SH_FSR1L = 3'h5;
  localparam logic [2:0] SH_FSR1H = 3'h6;
  localparam logic [2:0] SH_PC_LATCH_HIGH = 3'h7;
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int EXT_PINS = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE_STEP} run_st_t;
endpackage

// ===== interrupt_control_unit.sv
// interrupt control unit: flags, enables, vectoring, context shadow, wake
`timescale 1ns/1ps
module interrupt_control_unit
  import irq_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [irq_ctrl_pkg::EXT_PINS-1:0] ext_pins,
  input wire logic timer0_event,
  input wire logic pin_change_event,
  input wire logic [7:0] periph_event,
  input wire logic core_sleeping,
  input wire logic core_return_from_irq_instr,
  input wire logic [7:0] ctx_working_register,
  input wire logic [7:0] ctx_status,
  input wire logic [7:0] ctx_bsr,
  input wire logic [15:0] ctx_fsr0,
  input wire logic [15:0] ctx_fsr1,
  input wire logic [7:0] ctx_pc_latch_high,
  output logic q1_tick,
  output logic irq_take,
  output logic [14:0] irq_vector,
  output logic wake_request,
  output logic restore_valid,
  output logic [7:0] rst_working_register,
  output logic [7:0] rst_status,
  output logic [7:0] rst_bsr,
  output logic [15:0] rst_fsr0,
  output logic [15:0] rst_fsr1,
  output logic [7:0] rst_pc_latch_high,
  output logic global_irq_enable,
  output logic irq_pending
);
  import irq_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] interrupt_control;
    logic [7:0] periph_irq_enable_0;
    logic [7:0] periph_irq_enable_1;
    logic [7:0] pir0;
    logic [7:0] pir1;
    logic [2:0] pin_sel;
    logic [SHADOW_N-1:0][7:0] shadow;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    run_st_t run_st;
    logic wake;
    logic take;
    logic restore;
    logic aw_got;
    logic [15:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic q1;
  logic pend0;
  logic pend1;
  logic pending;
  logic wake_cond;
  logic ext_edge;
  logic commit;

  // read decode: hit flag and byte
  function automatic logic [8:0] reg_read(input logic [15:0] a, input state_t st);
    logic [8:0] r;
    r = 9'h000;
    if (a[15:5] == ADDR_SHADOW0[15:5] && a[1:0] == 2'h0)
    begin
      r = {1'b1, st.shadow[a[4:2]]};
    end
    else
    begin
      unique case (a)
        ADDR_INTERRUPT_CONTROL: r = {1'b1, st.interrupt_control};
        ADDR_PERIPH_IRQ_ENABLE_0: r = {1'b1, st.periph_irq_enable_0};
        ADDR_PERIPH_IRQ_ENABLE_1: r = {1'b1, st.periph_irq_enable_1};
        ADDR_PIR0: r = {1'b1, st.pir0};
        ADDR_PIR1: r = {1'b1, st.pir1};
        ADDR_PINSEL: r = {1'b1, 5'h00, st.pin_sel};
        default: r = 9'h000;
      endcase
    end
    return r;
  endfunction

  assign q1 = (state_reg.phase == Q1_PHASE);
  // pending is flag and enable, the second register also gated by the group enable, evaluated every cycle
  assign pend0 = |(state_reg.periph_irq_enable_0 & state_reg.pir0);
  assign pend1 = state_reg.interrupt_control[PERIPH_GROUP_ENABLE_BIT] & |(state_reg.periph_irq_enable_1 & state_reg.pir1);
  assign pending = pend0 | pend1;
  assign wake_cond = |(state_reg.periph_irq_enable_0 & state_reg.pir0 & WAKE_MASK0);
  // selected pin edge after the synchroniser
  assign ext_edge = state_reg.interrupt_control[EDGE_BIT]
    ? (state_reg.pin_sync & ~state_reg.pin_prev)
    : (~state_reg.pin_sync & state_reg.pin_prev);
  assign commit = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;

  always_comb
  begin
    logic [8:0] rd;
    logic [15:0] wa;
    logic [7:0] wd;
    logic wr;
    state_next = state_reg;
    rd = reg_read(s_axi_araddr, state_reg);
    wa = state_reg.aw_addr;
    wd = state_reg.w_data;
    wr = commit & state_reg.w_lane0;
    state_next.phase = state_reg.phase + PHASE_STEP;
    state_next.take = 1'b0;
    state_next.restore = 1'b0;
    // pin select mux ahead of the two-flop synchroniser
    state_next.pin_meta = ext_pins[state_reg.pin_sel];
    state_next.pin_sync = state_reg.pin_meta;
    state_next.pin_prev = state_reg.pin_sync;
    // bus channel handshakes
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_axi_wdata[7:0];
      state_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd[7:0];
      state_next.rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
    end
    // register write commit
    if (commit)
    begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = reg_read(wa, state_reg) >> 8 == 9'h001 ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr)
    begin
      if (wa[15:5] == ADDR_SHADOW0[15:5] && wa[1:0] == 2'h0)
      begin
        state_next.shadow[wa[4:2]] = wd;
      end
      else
      begin
        unique case (wa)
          ADDR_INTERRUPT_CONTROL: state_next.interrupt_control = wd & INTERRUPT_CONTROL_MASK;
          ADDR_PERIPH_IRQ_ENABLE_0: state_next.periph_irq_enable_0 = wd & PERIPH_IRQ_ENABLE_0_MASK;
          ADDR_PERIPH_IRQ_ENABLE_1: state_next.periph_irq_enable_1 = wd & PERIPH_IRQ_ENABLE_1_MASK;
          ADDR_PIR0: state_next.pir0 = wd & PERIPH_IRQ_ENABLE_0_MASK;
          ADDR_PIR1: state_next.pir1 = wd & PERIPH_IRQ_ENABLE_1_MASK;
          ADDR_PINSEL: state_next.pin_sel = wd[2:0];
          default: state_next.pin_sel = state_reg.pin_sel;
        endcase
      end
    end
    // events set flags whatever the enables; set wins over a clear
    state_next.pir0[TMR0_BIT] = state_next.pir0[TMR0_BIT] | timer0_event;
    state_next.pir0[IOC_BIT] = state_next.pir0[IOC_BIT] | pin_change_event;
    state_next.pir0[EXT_BIT] = state_next.pir0[EXT_BIT] | ext_edge;
    state_next.pir1 = state_next.pir1 | (periph_event & PERIPH_IRQ_ENABLE_1_MASK);
    // return from interrupt
    if (core_return_from_irq_instr)
    begin
      state_next.interrupt_control[GIE_BIT] = 1'b1;
      state_next.restore = 1'b1;
    end
    // sleep and wake sequencing
    if (!core_sleeping)
    begin
      state_next.wake = 1'b0;
    end
    unique case (state_reg.run_st)
      ST_RUN:
      begin
        if (core_sleeping)
        begin
          state_next.run_st = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (!core_sleeping)
        begin
          state_next.run_st = ST_RUN;
        end
        else if (wake_cond)
        begin
          state_next.wake = 1'b1;
          state_next.run_st = ST_WAKE_STEP;
        end
      end
      ST_WAKE_STEP:
      begin
        // one instruction runs before any vectoring
        if (q1 && !core_sleeping)
        begin
          state_next.run_st = ST_RUN;
        end
      end
    endcase
    // vectoring, sampled once per instruction cycle
    if (q1 && state_reg.run_st == ST_RUN && !core_sleeping && !core_return_from_irq_instr
        && state_reg.interrupt_control[GIE_BIT] && pending)
    begin
      state_next.take = 1'b1;
      state_next.interrupt_control[GIE_BIT] = 1'b0;
      state_next.shadow[SH_WORKING_REGISTER] = ctx_working_register;
      state_next.shadow[SH_STATUS] = ctx_status & STATUS_SAVE_MASK;
      state_next.shadow[SH_BSR] = ctx_bsr;
      state_next.shadow[SH_FSR0L] = ctx_fsr0[7:0];
      state_next.shadow[SH_FSR0H] = ctx_fsr0[15:8];
      state_next.shadow[SH_FSR1L] = ctx_fsr1[7:0];
      state_next.shadow[SH_FSR1H] = ctx_fsr1[15:8];
      state_next.shadow[SH_PC_LATCH_HIGH] = ctx_pc_latch_high;
    end
    if (!aresetn)
    begin
      state_next = '0;
      state_next.interrupt_control = INTERRUPT_CONTROL_RESET;
      state_next.run_st = ST_RUN;
    end
  end

  always_ff @(posedge aclk)
  begin
    state_reg <= state_next;
  end

  assign s_axi_awready = ~state_reg.aw_got & ~state_reg.bvalid;
  assign s_axi_wready = ~state_reg.w_got & ~state_reg.bvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = ~state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = {24'h000000, state_reg.rdata};
  assign q1_tick = q1;
  assign irq_take = state_reg.take;
  assign irq_vector = IRQ_VECTOR;
  assign wake_request = state_reg.wake;
  assign restore_valid = state_reg.restore;
  assign rst_working_register = state_reg.shadow[SH_WORKING_REGISTER];
  assign rst_status = state_reg.shadow[SH_STATUS];
  assign rst_bsr = state_reg.shadow[SH_BSR];
  assign rst_fsr0 = {state_reg.shadow[SH_FSR0H], state_reg.shadow[SH_FSR0L]};
  assign rst_fsr1 = {state_reg.shadow[SH_FSR1H], state_reg.shadow[SH_FSR1L]};
  assign rst_pc_latch_high = state_reg.shadow[SH_PC_LATCH_HIGH];
  assign global_irq_enable = state_reg.interrupt_control[GIE_BIT];
  assign irq_pending = pending;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_enables: assert property ($rose(aresetn) |-> !state_reg.interrupt_control[GIE_BIT]
    && !state_reg.interrupt_control[PERIPH_GROUP_ENABLE_BIT] && state_reg.interrupt_control[EDGE_BIT])
    else $error("enables not at reset values");
  a_take_cause: assert property (irq_take |-> $past(q1) && $past(pending)
    && $past(state_reg.interrupt_control[GIE_BIT]))
    else $error("vector taken without an enabled request at phase one");
  a_group_bypass: assert property (q1 && state_reg.run_st == ST_RUN && !core_sleeping
    && !core_return_from_irq_instr && state_reg.interrupt_control[GIE_BIT] && !state_reg.interrupt_control[PERIPH_GROUP_ENABLE_BIT] && pend0
    |=> irq_take)
    else $error("first-register source did not vector");
  a_flag_sets: assert property (timer0_event |=> state_reg.pir0[TMR0_BIT])
    else $error("event did not set its flag");
  a_take_entry: assert property (irq_take |-> !state_reg.interrupt_control[GIE_BIT]
    && irq_vector == IRQ_VECTOR)
    else $error("entry did not clear global enable");
  a_gie_off_quiet: assert property (!state_reg.interrupt_control[GIE_BIT] |=> !irq_take)
    else $error("vector taken with global enable clear");
  a_return_from_irq_instr_exit: assert property (core_return_from_irq_instr |=> restore_valid
    && state_reg.interrupt_control[GIE_BIT])
    else $error("return did not restore and re-enable");
  a_wake_step: assert property (state_reg.run_st == ST_WAKE_STEP |=> !irq_take)
    else $error("vector before the post-sleep instruction");
  a_shadow_save: assert property (irq_take |-> rst_working_register == $past(ctx_working_register)
    && rst_status == ($past(ctx_status) & STATUS_SAVE_MASK))
    else $error("context not saved on entry");
  a_ext_edge: assert property (ext_edge |=> state_reg.pir0[EXT_BIT])
    else $error("pin edge did not set its flag");
  a_flag_sticky: assert property (state_reg.pir1[0] && !commit |=> state_reg.pir1[0])
    else $error("flag dropped without a write");
  a_wake_raise: assert property (state_reg.run_st == ST_SLEEP && core_sleeping && wake_cond
    |=> wake_request ##1 (wake_request || !$past(core_sleeping)))
    else $error("enabled clockless source did not wake");

  c_take: cover property (irq_take);
  c_return: cover property (irq_take ##[1:200] restore_valid);
  c_wake: cover property (wake_request ##[1:50] irq_take);
  c_ext_flag: cover property (ext_edge && !state_reg.interrupt_control[EDGE_BIT]);
endmodule

// ===== core_model.sv
// behavioural processor core: sleep, wake and return from interrupt
`timescale 1ns/1ps
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wake_request,
  input wire logic sleep_cmd,
  input wire logic ret_cmd,
  output logic core_sleeping,
  output logic core_return_from_irq_instr
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_sleeping <= 1'b0;
      core_return_from_irq_instr <= 1'b0;
    end
    else
    begin
      core_return_from_irq_instr <= ret_cmd;
      // sleep holds until the controller asks for a wake
      if (sleep_cmd)
        core_sleeping <= 1'b1;
      else if (wake_request)
        core_sleeping <= 1'b0;
    end
  end
endmodule

// ===== interrupt_control_unit_tb.sv
// self-checking bench of the interrupt control unit
`timescale 1ns/1ps
module interrupt_control_unit_tb;
  import irq_ctrl_pkg::*;
  localparam int TAKE = 0, WAKE = 1, RESTORE = 2;
  logic aclk, awready, wready, bvalid, arready, rvalid, core_sleeping, core_return_from_irq_instr, q1_tick;
  logic irq_take, wake_request, restore_valid, global_irq_enable, irq_pending;
  logic aresetn = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic timer0_event = 0, pin_change_event = 0, sleep_cmd = 0, ret_cmd = 0, q1p = 0;
  logic [15:0] awaddr = 0, araddr = 0, ctx_fsr0 = 0, ctx_fsr1 = 0, snap;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] ext_pins = 0, periph_event = 0, ctx_working_register = 0, ctx_status = 0, ctx_bsr = 0;
  logic [7:0] ctx_pc_latch_high = 0, pe, prv_w, prv_s, rst_working_register, rst_status;
  logic [14:0] irq_vector;
  logic [2:0] k;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  integer seed = 32'h874FEFB8;
  int err_count = 0, n_checks = 0, cycles = 0, awake_q1 = 0;
  bit chk_wake = 0;

  interrupt_control_unit i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_pins(ext_pins), .timer0_event(timer0_event),
    .pin_change_event(pin_change_event), .periph_event(periph_event),
    .core_sleeping(core_sleeping), .core_return_from_irq_instr(core_return_from_irq_instr), .ctx_working_register(ctx_working_register),
    .ctx_status(ctx_status), .ctx_bsr(ctx_bsr), .ctx_fsr0(ctx_fsr0), .ctx_fsr1(ctx_fsr1),
    .ctx_pc_latch_high(ctx_pc_latch_high), .q1_tick(q1_tick), .irq_take(irq_take), .irq_vector(irq_vector),
    .wake_request(wake_request), .restore_valid(restore_valid), .rst_working_register(rst_working_register),
    .rst_status(rst_status), .rst_bsr(), .rst_fsr0(), .rst_fsr1(), .rst_pc_latch_high(),
    .global_irq_enable(global_irq_enable), .irq_pending(irq_pending));

  core_model i_core (.aclk(aclk), .aresetn(aresetn), .wake_request(wake_request),
    .sleep_cmd(sleep_cmd), .ret_cmd(ret_cmd), .core_sleeping(core_sleeping),
    .core_return_from_irq_instr(core_return_from_irq_instr));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    bit ad, wd;
    ad = 0;
    wd = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, 24'h0, e});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask

  function automatic logic sig(input int sel);
    return sel == TAKE ? irq_take : sel == WAKE ? wake_request : restore_valid;
  endfunction

  // waits a bounded number of cycles for a design output, then compares it
  task automatic await(input int sel, input logic e, input int lim);
    int n;
    n = 0;
    while (sig(sel) !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    check(sig(sel), e);
  endtask

  task automatic ev(input logic t, input logic p, input logic [7:0] e);
    timer0_event <= t;
    pin_change_event <= p;
    periph_event <= e;
    @(posedge aclk);
    timer0_event <= 1'b0;
    pin_change_event <= 1'b0;
    periph_event <= 8'h00;
  endtask

  task automatic core_cmd(input logic slp);
    sleep_cmd <= slp;
    ret_cmd <= !slp;
    @(posedge aclk);
    sleep_cmd <= 1'b0;
    ret_cmd <= 1'b0;
  endtask

  task automatic pins(input logic [7:0] v, input logic [7:0] e);
    ext_pins <= v;
    repeat (6) @(posedge aclk);
    rd(ADDR_PIR0, e);
  endtask

  // live core context changes every cycle so a stale shadow shows
  always @(posedge aclk)
  begin
    {ctx_working_register, ctx_status, ctx_bsr, ctx_pc_latch_high} <= $random(seed);
    {ctx_fsr0, ctx_fsr1} <= $random(seed);
  end

  always @(posedge aclk)
  begin
    if (bvalid && bready) check(bresp, bq.pop_front());
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
    if (irq_take) check(irq_vector, IRQ_VECTOR);
    if (irq_take) check(q1p, 1'b1);
    if (irq_take && chk_wake) check(awake_q1 >= 2, 1'b1);
    if (irq_take) snap = {prv_s & STATUS_SAVE_MASK, prv_w};
    prv_w = ctx_working_register;
    prv_s = ctx_status;
    q1p = q1_tick;
    awake_q1 = core_sleeping ? 0 : awake_q1 + int'(q1_tick);
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(global_irq_enable, 1'b0);
    rd(ADDR_INTERRUPT_CONTROL, INTERRUPT_CONTROL_RESET);
    rd(ADDR_PERIPH_IRQ_ENABLE_0, 8'h00);
    rd(ADDR_PERIPH_IRQ_ENABLE_1, 8'h00);
    rd(16'h0010, 8'h00, RESP_SLVERR);
    wr(16'h0010, 8'hFF, RESP_SLVERR);
    wr(ADDR_INTERRUPT_CONTROL, 8'hFF);
    rd(ADDR_INTERRUPT_CONTROL, INTERRUPT_CONTROL_MASK);
    wr(ADDR_PERIPH_IRQ_ENABLE_0, 8'hFF);
    rd(ADDR_PERIPH_IRQ_ENABLE_0, PERIPH_IRQ_ENABLE_0_MASK);
    wr(ADDR_PERIPH_IRQ_ENABLE_1, 8'hFF);
    rd(ADDR_PERIPH_IRQ_ENABLE_1, PERIPH_IRQ_ENABLE_1_MASK);
    wr(ADDR_PERIPH_IRQ_ENABLE_0, 8'h00);
    wr(ADDR_PERIPH_IRQ_ENABLE_1, 8'h00);
    pe = ctx_working_register | 8'h80;
    ev(1'b1, 1'b1, pe);
    await(TAKE, 1'b0, 12);
    check(irq_pending, 1'b0);
    rd(ADDR_PIR0, 8'h30);
    rd(ADDR_PIR1, pe & 8'hFD);
    wr(ADDR_PIR0, 8'h00);
    wr(ADDR_PERIPH_IRQ_ENABLE_0, 8'h20);
    wr(ADDR_INTERRUPT_CONTROL, 8'h81);
    ev(1'b1, 1'b0, 8'h00);
    await(TAKE, 1'b1, 20);
    @(posedge aclk);
    check(global_irq_enable, 1'b0);
    rd(ADDR_SHADOW0, snap[7:0]);
    rd(ADDR_SHADOW0 + 16'h4, snap[15:8]);
    await(TAKE, 1'b0, 12);
    wr(ADDR_SHADOW0, 8'h5A);
    rd(ADDR_SHADOW0, 8'h5A);
    wr(ADDR_PIR0, 8'h00);
    core_cmd(1'b0);
    await(RESTORE, 1'b1, 8);
    check(rst_working_register, 8'h5A);
    check(rst_status, snap[15:8]);
    check(global_irq_enable, 1'b1);
    await(TAKE, 1'b0, 12);
    wr(ADDR_PERIPH_IRQ_ENABLE_1, 8'h80);
    await(TAKE, 1'b0, 12);
    wr(ADDR_INTERRUPT_CONTROL, 8'hC1);
    await(TAKE, 1'b1, 24);
    wr(ADDR_INTERRUPT_CONTROL, 8'hC1);
    await(TAKE, 1'b1, 24);
    wr(ADDR_PIR1, 8'h00);
    wr(ADDR_PERIPH_IRQ_ENABLE_1, 8'h00);
    wr(ADDR_PERIPH_IRQ_ENABLE_0, 8'h00);
    k = ctx_working_register[2:0];
    wr(ADDR_PINSEL, {5'h0, k});
    wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    pins(~(8'h01 << k), 8'h00);
    pins(8'hFF, 8'h00);
    pins(~(8'h01 << k), 8'h01);
    wr(ADDR_PIR0, 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'h01);
    pins(8'hFF, 8'h01);
    wr(ADDR_PERIPH_IRQ_ENABLE_0, 8'h01);
    wr(ADDR_INTERRUPT_CONTROL, 8'h81);
    await(TAKE, 1'b1, 24);
    wr(ADDR_PIR0, 8'h00);
    core_cmd(1'b0);
    await(RESTORE, 1'b1, 8);
    wr(ADDR_PERIPH_IRQ_ENABLE_0, 8'h10);
    wr(ADDR_INTERRUPT_CONTROL, 8'h01);
    core_cmd(1'b1);
    ev(1'b0, 1'b1, 8'h00);
    await(WAKE, 1'b1, 8);
    await(TAKE, 1'b0, 16);
    wr(ADDR_PIR0, 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'h81);
    chk_wake = 1;
    core_cmd(1'b1);
    ev(1'b0, 1'b1, 8'h00);
    await(WAKE, 1'b1, 8);
    await(TAKE, 1'b1, 24);
    stop_test();
  end
endmodule
